/* File: design/sps_pkg.sv */
// Shared constants and carrier types for the pipelined synchronous SRAM port
package sps_pkg;

    // Pin widths
    localparam int ADDR_W = 19;
    localparam int LANE_W = 9;
    localparam int BW_W = 2;
    localparam int DATA_W = 18;

    // Local storage: index width of the flip-flop array
    localparam int MEM_AW = 6;

    // Write buffer depth, power of two
    localparam int BUF_DEPTH = 32;

    // Burst counter values
    localparam logic [1:0] STEP_ZERO = 2'h0;
    localparam logic [1:0] STEP_ONE = 2'h1;

    // Reset values of synchronised asynchronous inputs
    localparam logic OE_N_RST = 1'b1;
    localparam logic SLEEP_RST = 1'b0;
    localparam logic ORDER_RST = 1'b1;

    // Burst sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BURST = 2'b10
    } sps_burst_t;

    // One accepted command travelling down the pipeline
    typedef struct packed {
        logic vld;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [BW_W-1:0] bw_n;
    } sps_cmd_t;

    // One captured write waiting for the storage array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BW_W-1:0] bw_n;
        logic [DATA_W-1:0] data;
    } sps_wr_t;

    localparam sps_cmd_t CMD_IDLE = '0;

endpackage

/* File: design/sps_sram_port.sv */
// Pipelined synchronous SRAM device port: syncs, write buffer and top level
`timescale 1ns/1ps

// Three-flop synchroniser; output moves once stages two and three agree
module sps_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_reg <= RST_VAL;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= (s2_reg == s3_reg) ? s3_reg : q_reg; // Ignores a level seen only once
        end
    end

    assign q = q_reg;
endmodule

// Flop-based FIFO; depth must be a power of two so pointers wrap freely
module sps_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // Handshake decode
    assign in_ready = cnt_reg != FULL_CNT;
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers and fill count
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_reg + AW'(push);
            rp_reg <= rp_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wp_reg] <= in_data;
        end
    end
endmodule

// How it works
// RULE1: Read/write level sampled at load fixes direction for the whole burst.
// RULE2: Data for an accepted cycle moves exactly two rising edges after the command.
// RULE3: Everything except output enable, sleep and burst order follows the rising edge.
// RULE4: Any chip select inactive with advance/load low starts a deselect cycle.
// RULE5: Data pins go high impedance two cycles after a deselect starts.
// RULE6: Second chip select is active high; all three must be active to select.
// RULE7: Read data drives only while output enable is low.
// RULE8: Controller may hold output enable low; turnaround is handled inside.
// RULE9: Advance/load low while selected captures new address and controls.
// RULE10: Advance/load high steps the burst counter of a running burst.
// RULE11: Address and read/write select are ignored while advance/load is high.
// RULE12: Burst order high selects interleaved, low selects linear sequence.
// RULE13: Controller keeps burst order static during operation.
// RULE14: Sleep input high puts the device in low-power standby.
// RULE15: Controller keeps sleep low for normal operation.
// RULE16: Write and read data pass registers per nine-bit byte lane.
// RULE17: Clock gate high freezes all inputs, outputs and internal state. Here lane enables, sleep status, buffer ready and the syncs still update.
// RULE18: Byte write enables sampled on every write cycle, applied two cycles later.
// RULE19: The two low address bits preload the burst counter start.
// RULE20: After the fourth address the counter wraps and keeps counting.
// RULE21: Deselect ends a burst but pipelined transfers still complete.
// RULE22: A burst is four data cycles from one loaded address.
module sps_sram_port
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Command pins
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic READ_WRITE_N,
    input wire logic CHIP_SEL_FIRST_N,
    input wire logic CHIP_SEL_SECOND_HI,
    input wire logic CHIP_SEL_THIRD_N,
    input wire logic ADVANCE_LOAD_N,
    input wire logic CLOCK_GATE_N,
    input wire logic [BW_W-1:0] BYTE_WRITE_EN_N,
    // Asynchronous and static pins
    input wire logic OUT_EN_N,
    input wire logic BURST_ORDER,
    input wire logic SLEEP_REQ,
    // Byte lane a
    input wire logic [LANE_W-1:0] BYTE_LANE_A_IN,
    output logic [LANE_W-1:0] BYTE_LANE_A_OUT,
    output logic BYTE_LANE_A_OE,
    // Byte lane b
    input wire logic [LANE_W-1:0] BYTE_LANE_B_IN,
    output logic [LANE_W-1:0] BYTE_LANE_B_OUT,
    output logic BYTE_LANE_B_OE,
    // Status
    output logic SLEEP_ACTIVE,
    output logic WRITE_BUF_READY
);
    sps_burst_t st_reg;
    sps_burst_t st_next;
    logic [ADDR_W-1:0] base_reg;
    logic [ADDR_W-1:0] base_next;
    logic [1:0] start_reg;
    logic [1:0] start_next;
    logic [1:0] step_reg;
    logic [1:0] step_next;
    logic wr_reg;
    logic wr_next;
    sps_cmd_t s1_reg;
    sps_cmd_t s1_next;
    sps_cmd_t s2_reg;
    logic [DATA_W-1:0] rd_reg;
    logic [DATA_W-1:0] rd_next;
    logic drive_reg;
    logic drive_next;
    logic lane_oe_reg;
    logic sleep_reg;
    logic buf_rdy_reg;
    logic [DATA_W-1:0] store [2**MEM_AW];

    logic oe_n_q;
    logic sleep_q;
    logic order_q;
    logic run;
    logic sel;
    logic load;
    logic start;
    logic advance;
    logic [1:0] step_inc;
    logic [1:0] burst_lo;
    logic [ADDR_W-1:0] burst_addr;
    sps_wr_t wr_in;
    sps_wr_t head;
    logic push_vld;
    logic buf_in_rdy;
    logic head_vld;
    logic drain;
    logic head_hit;
    logic [MEM_AW-1:0] rd_idx;
    logic [DATA_W-1:0] rd_raw;

    // Asynchronous and static inputs
    sps_sync #(.RST_VAL(OE_N_RST)) u_oe_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d(OUT_EN_N),
        .q(oe_n_q)
    );
    sps_sync #(.RST_VAL(SLEEP_RST)) u_sleep_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d(SLEEP_REQ),
        .q(sleep_q)
    );
    sps_sync #(.RST_VAL(ORDER_RST)) u_order_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d(BURST_ORDER),
        .q(order_q)
    );

    // Command decode; a sleeping device accepts no new access
    assign run = !CLOCK_GATE_N; // RULE17
    assign sel = !CHIP_SEL_FIRST_N && CHIP_SEL_SECOND_HI && !CHIP_SEL_THIRD_N; // RULE6
    assign load = !ADVANCE_LOAD_N;
    assign start = load && sel && !sleep_q; // RULE9
    assign advance = !load && st_reg == ST_BURST; // RULE10

    // Burst address generation
    assign step_inc = step_reg + STEP_ONE; // RULE20
    assign burst_lo = order_q ? (start_reg ^ step_inc) : (start_reg + step_inc); // RULE12
    assign burst_addr = {base_reg[ADDR_W-1:2], burst_lo}; // RULE22

    // Burst sequencer and stage-one command
    always_comb
    begin
        st_next = st_reg;
        base_next = base_reg;
        start_next = start_reg;
        step_next = step_reg;
        wr_next = wr_reg;
        s1_next = CMD_IDLE;
        unique case (st_reg)
            ST_IDLE: st_next = start ? ST_BURST : ST_IDLE;
            ST_BURST: st_next = (load && !start) ? ST_IDLE : ST_BURST; // RULE4 RULE21
        endcase
        if (start)
        begin
            base_next = ADDR;
            start_next = ADDR[1:0]; // RULE19
            step_next = STEP_ZERO;
            wr_next = !READ_WRITE_N; // RULE1
            s1_next.vld = 1'b1;
            s1_next.wr = !READ_WRITE_N;
            s1_next.addr = ADDR;
            s1_next.bw_n = BYTE_WRITE_EN_N; // RULE18
        end
        else if (advance)
        begin
            step_next = step_inc; // RULE10 RULE20
            s1_next.vld = 1'b1;
            s1_next.wr = wr_reg; // RULE11 RULE1
            s1_next.addr = burst_addr;
            s1_next.bw_n = BYTE_WRITE_EN_N; // RULE18
        end
    end

    // Command pipeline; clock gate holds every stage
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            st_reg <= ST_IDLE;
            base_reg <= '0;
            start_reg <= STEP_ZERO;
            step_reg <= STEP_ZERO;
            wr_reg <= 1'b0;
            s1_reg <= CMD_IDLE;
            s2_reg <= CMD_IDLE;
        end
        else if (run) // RULE17 RULE3
        begin
            st_reg <= st_next;
            base_reg <= base_next;
            start_reg <= start_next;
            step_reg <= step_next;
            wr_reg <= wr_next;
            s1_reg <= s1_next;
            s2_reg <= s1_reg; // RULE2
        end
    end

    // Write capture two edges after the command
    assign push_vld = run && s2_reg.vld && s2_reg.wr; // RULE2 RULE18
    assign wr_in.addr = s2_reg.addr;
    assign wr_in.bw_n = s2_reg.bw_n;
    assign wr_in.data = {BYTE_LANE_B_IN, BYTE_LANE_A_IN}; // RULE16

    // Drain stalls in sleep and under clock gate, so the buffer can fill
    assign drain = run && !sleep_q; // RULE14

    sps_fifo #(.W($bits(sps_wr_t)), .D(BUF_DEPTH)) u_wbuf (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .in_valid(push_vld),
        .in_ready(buf_in_rdy),
        .in_data(wr_in),
        .out_valid(head_vld),
        .out_ready(drain),
        .out_data(head)
    );

    // Storage array update, per byte lane
    always_ff @(posedge CLK_SYS)
    begin
        for (int i = 0; i < BW_W; i++)
        begin
            if (head_vld && drain && !head.bw_n[i])
            begin
                store[head.addr[MEM_AW-1:0]][i*LANE_W +: LANE_W] <= head.data[i*LANE_W +: LANE_W];
            end
        end
    end

    // Read lookup; the buffer head is forwarded because it is not yet in the array.
    // Without stalls the buffer holds at most one entry, so the head is enough.
    assign rd_idx = s2_reg.addr[MEM_AW-1:0];
    assign rd_raw = store[rd_idx];
    assign head_hit = head_vld && head.addr[MEM_AW-1:0] == rd_idx;

    always_comb
    begin
        rd_next = rd_reg;
        drive_next = drive_reg;
        if (run)
        begin
            drive_next = s2_reg.vld && !s2_reg.wr && !sleep_q; // RULE5 RULE21
            for (int i = 0; i < BW_W; i++)
            begin
                rd_next[i*LANE_W +: LANE_W] = (head_hit && !head.bw_n[i]) ?
                    head.data[i*LANE_W +: LANE_W] : rd_raw[i*LANE_W +: LANE_W];
            end
        end
    end

    // Output registers; enable follows output-enable every edge
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            rd_reg <= '0;
            drive_reg <= 1'b0;
            lane_oe_reg <= 1'b0;
            sleep_reg <= 1'b0;
            buf_rdy_reg <= 1'b0;
        end
        else
        begin
            rd_reg <= rd_next; // RULE16
            drive_reg <= drive_next;
            lane_oe_reg <= drive_next && !oe_n_q && !sleep_q; // RULE7 RULE14
            sleep_reg <= sleep_q; // RULE14
            buf_rdy_reg <= buf_in_rdy;
        end
    end

    // Pin drivers
    assign BYTE_LANE_A_OUT = rd_reg[LANE_W-1:0];
    assign BYTE_LANE_B_OUT = rd_reg[DATA_W-1:LANE_W];
    assign BYTE_LANE_A_OE = lane_oe_reg;
    assign BYTE_LANE_B_OE = lane_oe_reg;
    assign SLEEP_ACTIVE = sleep_reg;
    assign WRITE_BUF_READY = buf_rdy_reg;
endmodule

/* File: test/sps_ctrl_model.sv */
// Memory controller model driving the SRAM port command pins
`timescale 1ns/1ps
module sps_ctrl_model
    import sps_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command pins, selects as third_n, second_hi, first_n
    output logic [ADDR_W-1:0] addr,
    output logic rw_n,
    output logic [2:0] cs,
    output logic adv_n,
    output logic gate_n,
    output logic [BW_W-1:0] bw_n,
    // Write data for both lanes
    output logic [DATA_W-1:0] wdata
);
    logic [DATA_W-1:0] d0 = '0;
    logic [DATA_W-1:0] d1 = '0;

    // Start deselected with the clock gate open
    initial
    begin
        addr = '0;
        rw_n = 1'b1;
        cs = 3'h3;
        adv_n = 1'b0;
        gate_n = 1'b0;
        bw_n = 2'h3;
        wdata = '0;
    end

    // One cycle after a falling edge; gated edges do not move the data pipe
    task automatic cmd(input logic g, input logic l_n, input logic [2:0] c, input logic rw,
        input logic [ADDR_W-1:0] a, input logic [BW_W-1:0] b, input logic [DATA_W-1:0] d);
    begin
        @(negedge clk);
        gate_n = g;
        adv_n = l_n;
        cs = c;
        rw_n = rw;
        addr = a;
        bw_n = b;
        if (!g)
        begin
            wdata = d1;
            d1 = d0;
            d0 = d;
        end
    end
    endtask
endmodule

/* File: test/sps_checker.sv */
// Pin-level checks on the SRAM port
`timescale 1ns/1ps
module sps_checker
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Command, output-enable and sleep pins
    input wire logic READ_WRITE_N,
    input wire logic CHIP_SEL_FIRST_N,
    input wire logic CHIP_SEL_SECOND_HI,
    input wire logic CHIP_SEL_THIRD_N,
    input wire logic ADVANCE_LOAD_N,
    input wire logic CLOCK_GATE_N,
    input wire logic OUT_EN_N,
    input wire logic SLEEP_REQ,
    // Outputs
    input wire logic [LANE_W-1:0] BYTE_LANE_A_OUT,
    input wire logic [LANE_W-1:0] BYTE_LANE_B_OUT,
    input wire logic BYTE_LANE_A_OE,
    input wire logic BYTE_LANE_B_OE,
    input wire logic SLEEP_ACTIVE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    // Ungated load and full selection
    wire ld = !ADVANCE_LOAD_N && !CLOCK_GATE_N;
    wire sel = !CHIP_SEL_FIRST_N && CHIP_SEL_SECOND_HI && !CHIP_SEL_THIRD_N;

    property p_rst;
        disable iff (1'b0) SYS_RST |=> !BYTE_LANE_A_OE && !SLEEP_ACTIVE;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    property p_pair;
        BYTE_LANE_A_OE == BYTE_LANE_B_OE;
    endproperty
    a_pair: assert property (p_pair) else $error("lane enables differ");
    property p_desel;
        (ld && !sel) ##1 !CLOCK_GATE_N ##1 !CLOCK_GATE_N |=> !BYTE_LANE_A_OE;
    endproperty
    a_desel: assert property (p_desel) else $error("bus driven after deselect");
    property p_second;
        (ld && !CHIP_SEL_SECOND_HI) ##1 !CLOCK_GATE_N ##1 !CLOCK_GATE_N |=> !BYTE_LANE_A_OE;
    endproperty
    a_second: assert property (p_second) else $error("low second select drove bus");
    property p_write;
        (ld && sel && !READ_WRITE_N) ##1 !CLOCK_GATE_N ##1 !CLOCK_GATE_N |=> !BYTE_LANE_A_OE;
    endproperty
    a_write: assert property (p_write) else $error("bus driven in write slot");
    property p_read;
        ((!OUT_EN_N && !SLEEP_REQ)[*8] ##0 (ld && sel && READ_WRITE_N)) ##1
            (!CLOCK_GATE_N && !OUT_EN_N)[*2] |=> BYTE_LANE_A_OE;
    endproperty
    a_read: assert property (p_read) else $error("read data not driven");
    property p_oe;
        OUT_EN_N[*8] |-> !BYTE_LANE_A_OE;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven while disabled");
    property p_sleep;
        SLEEP_REQ[*8] |-> SLEEP_ACTIVE && !BYTE_LANE_A_OE;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_gate;
        CLOCK_GATE_N |=> $stable(BYTE_LANE_A_OUT) && $stable(BYTE_LANE_B_OUT);
    endproperty
    a_gate: assert property (p_gate) else $error("data moved on gated edge");
endmodule

bind sps_sram_port sps_checker u_chk (.*);

/* File: test/tb_top.sv */
// Self-checking bench for the pipelined SRAM port
`timescale 1ns/1ps
module tb_top
    import sps_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic oe_n = 1'b0;
    logic order = 1'b1;
    logic sleep = 1'b0;
    logic gl = 1'b0;
    logic [31:0] r;
    logic [ADDR_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic rw_n;
    logic [2:0] cs;
    logic adv_n;
    logic gate_n;
    logic [BW_W-1:0] bw_n;
    logic [DATA_W-1:0] wdata;
    logic [LANE_W-1:0] a_out;
    logic [LANE_W-1:0] b_out;
    logic a_oe;
    logic b_oe;
    logic slp;
    logic wbr;
    logic [DATA_W-1:0] mem [64];
    logic [DATA_W-1:0] exq [$];
    logic [2:0] ds [3] = '{3'h3, 3'h0, 3'h6};
    int err_total = 0;
    int check_count = 0;

    sps_ctrl_model ctl (.clk(clk), .addr(addr), .rw_n(rw_n), .cs(cs), .adv_n(adv_n), .gate_n(gate_n),
        .bw_n(bw_n), .wdata(wdata));
    sps_sram_port DUT (.CLK_SYS(clk), .SYS_RST(rst), .ADDR(addr), .READ_WRITE_N(rw_n),
        .CHIP_SEL_FIRST_N(cs[0]), .CHIP_SEL_SECOND_HI(cs[1]), .CHIP_SEL_THIRD_N(cs[2]),
        .ADVANCE_LOAD_N(adv_n), .CLOCK_GATE_N(gate_n), .BYTE_WRITE_EN_N(bw_n), .OUT_EN_N(oe_n),
        .BURST_ORDER(order), .SLEEP_REQ(sleep), .BYTE_LANE_A_IN(wdata[8:0]), .BYTE_LANE_A_OUT(a_out),
        .BYTE_LANE_A_OE(a_oe), .BYTE_LANE_B_IN(wdata[17:9]), .BYTE_LANE_B_OUT(b_out),
        .BYTE_LANE_B_OE(b_oe), .SLEEP_ACTIVE(slp), .WRITE_BUF_READY(wbr));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic chk_bit(input string nm, input logic e, input logic g);
    begin
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    end
    endtask

    task automatic chk_word(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    begin
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED read data exp %h got %h", e, g);
        end
    end
    endtask

    task automatic complete_run;
    begin
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    // Deselect cycles; the idle data bus still toggles
    task automatic idle(input int n);
    begin
        repeat (n) ctl.cmd(1'b0, 1'b0, 3'h3, 1'b1, '0, 2'h3, DATA_W'($urandom));
    end
    endtask

    // One load plus n-1 advances, junk address and direction on advances, random gated edges
    task automatic burst(input logic rw, input logic [ADDR_W-1:0] a, input int n, input logic [1:0] bw,
        input logic ex);
        logic [1:0] s;
        logic [5:0] ix;
    begin
        for (int k = 0; k < n; k++)
        begin
            r = $urandom;
            if (r[1:0] == 2'h0)
                ctl.cmd(1'b1, r[2], r[5:3], r[6], r[31:13], r[8:7], r[26:9]);
            s = order ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
            ix = {a[5:2], s};
            r = $urandom;
            if (!rw)
                mem[ix] = {bw[1] ? mem[ix][17:9] : r[17:9], bw[0] ? mem[ix][8:0] : r[8:0]};
            else if (ex)
                exq.push_back(mem[ix]);
            ctl.cmd(1'b0, k != 0, 3'h2, rw ^ (k != 0), k != 0 ? r[31:13] : a, bw, r[17:0]);
        end
    end
    endtask

    // Read results land in order; an edge that was gated shows nothing new
    always @(posedge clk)
    begin
        if (a_oe === 1'b1 && !gl)
        begin
            if (exq.size() == 0)
                chk_bit("unexpected read", 1'b0, 1'b1);
            else
                chk_word(exq.pop_front(), {b_out, a_out});
        end
        gl = gate_n;
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial
    begin
        void'($urandom(17754));
        for (int o = 1; o >= 0; o--)
        begin
            rst = 1'b1;
            order = o[0];
            repeat (16) @(negedge clk);
            chk_bit("buffer ready in reset", 1'b0, wbr);
            rst = 1'b0;
            chk_bit("enable in reset", 1'b0, a_oe);
            idle(8);
            chk_bit("buffer ready", 1'b1, wbr);
            for (int i = 0; i < 16 && o == 1; i++)
                burst(1'b0, ADDR_W'(4 * i), 4, 2'h0, 1'b0);
            // Write then read back at once, six reads to see the wrap
            for (int i = 0; i < 6; i++)
            begin
                r = $urandom;
                ba = r[18:0];
                burst(1'b0, ba, 4, r[20:19], 1'b0);
                burst(1'b1, ba, 6, 2'h0, 1'b1);
            end
            // Deselect by each select cuts a read burst after two words
            foreach (ds[j])
            begin
                burst(1'b1, ADDR_W'($urandom), 2, 2'h0, 1'b1);
                ctl.cmd(1'b0, 1'b0, ds[j], 1'b1, '0, 2'h3, '0);
                ctl.cmd(1'b0, 1'b1, 3'h2, 1'b1, '0, 2'h3, '1);
                idle(2);
            end
            idle(4);
        end
        // Reads with output enable high drive nothing
        oe_n = 1'b1;
        idle(6);
        burst(1'b1, ADDR_W'($urandom), 4, 2'h0, 1'b0);
        idle(4);
        oe_n = 1'b0;
        sleep = 1'b1;
        idle(8);
        chk_bit("sleep status", 1'b1, slp);
        burst(1'b1, ADDR_W'($urandom), 4, 2'h0, 1'b0);
        sleep = 1'b0;
        idle(8);
        chk_bit("sleep status", 1'b0, slp);
        burst(1'b1, ADDR_W'($urandom), 4, 2'h0, 1'b1);
        idle(6);
        chk_bit("reads all seen", 1'b1, exq.size() == 0);
        complete_run();
    end
endmodule
